// *** common/ikr_pkg.sv ***
// constants shared by the initial reset generator
package ikr_pkg;
  localparam int          KEY_W       = 4;
  localparam int          PRS_W       = 4;
  // key combination options
  localparam int          OPT_NONE    = 1;
  localparam int          OPT_ALL4    = 2;
  localparam int          OPT_K3      = 3;
  localparam int          OPT_K2      = 4;
  localparam logic [3:0]  MASK_NONE   = 4'h0;
  localparam logic [3:0]  MASK_ALL4   = 4'hF;
  localparam logic [3:0]  MASK_K3     = 4'h7;
  localparam logic [3:0]  MASK_K2     = 4'h3;
  // oscillator periods per prescaler step
  localparam int          NR_BASE     = 256;
  localparam int          AUTH_BASE   = 524288;
  localparam int          REL_DIV_W   = 20;      // divide by 1048576
  // timing of the outside party, for reference
  localparam int          CLK_NS      = 10;
  localparam int          PIN_MIN_NS  = 100000;
  localparam int          PIN_MIN_CYC = (PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic {ST_RUN, ST_RESET} ikr_state_t;
endpackage : ikr_pkg

// *** rtl/ikr_low_timer.sv ***
// counts consecutive active cycles and flags a reached limit
`timescale 1ns/10ps
`default_nettype none
module ikr_low_timer #(
  parameter int CNT_W = 12
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_active,
  input  wire logic [CNT_W-1:0] i_limit,
  output logic                  o_done
);
  import ikr_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_done;

  // saturating count while active, cleared when the input ends
  always_comb begin
    next_cnt  = '0;
    next_done = 1'b0;
    if (i_active) begin
      next_cnt  = (cnt == i_limit) ? cnt : cnt + 1'b1;
      next_done = (cnt == i_limit);
    end
  end

  // register state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt    <= '0;
      o_done <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_done <= next_done;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  done_at_limit_a: assert property (
    $rose(o_done) |-> $past(cnt == i_limit))
    else $error("timer done without reaching the limit");
endmodule : ikr_low_timer
`default_nettype wire

// *** rtl/ikr_reset_gen.sv ***
// initial reset generator: reset pin and simultaneous-low key reset
// Functional notes
// - A low reset pin asserts the internal initial reset.
// - A latch holds reset; it releases only on rising edge of fosc/1048576.
// - After pin goes high, reset stays until latch release; CPU then runs.
// - Internal reset combines pin source and key simultaneous-low source.
// - All selected keys low together set the same reset latch.
// - Option 1 disables; option 2 needs four keys; option 3 first three.
// - Noise rejector drops key lows shorter than 256 times n periods.
// - n equals the prescaler setting plus one.
// - Rejector idle while oscillator stopped; keys held low past it.
// - Option 4 needs first two keys; wider key entries also reset.
// - With authorize fitted, key low must last 524288 times n periods.
// - In sleep, rejector and authorize are bypassed.
`timescale 1ns/10ps
`default_nettype none
module ikr_reset_gen #(
  parameter int KEY_OPT   = ikr_pkg::OPT_ALL4,
  parameter bit TIME_AUTH = 1'b0,
  parameter int AUTH_MUL  = ikr_pkg::AUTH_BASE,
  parameter int REL_W     = ikr_pkg::REL_DIV_W,
  parameter int NR_W      = 12,
  parameter int AU_W      = 23
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_reset_pin_n,
  input  wire logic [ikr_pkg::KEY_W-1:0] i_key_inputs,
  input  wire logic [ikr_pkg::PRS_W-1:0] i_prescaler_setting,
  input  wire logic                     i_sleep,
  output logic                          o_init_reset,
  output logic                          o_key_reset
);
  import ikr_pkg::*;

  localparam logic [REL_W-1:0] REL_EDGE = {1'b0, {(REL_W-1){1'b1}}};

  ikr_state_t       state;
  ikr_state_t       next_state;
  logic [REL_W-1:0] rel_cnt;
  logic [REL_W-1:0] next_rel_cnt;
  logic             rel_tick;
  logic             next_rel_tick;
  logic [1:0]       pin_sync;
  logic [KEY_W-1:0] key_meta;
  logic [KEY_W-1:0] key_sync;
  logic [KEY_W-1:0] key_mask;
  logic             combo_low;
  logic             pin_low;
  logic [PRS_W:0]   n_mul;
  logic [NR_W:0]    nr_full;
  logic [NR_W-1:0]  nr_limit;
  logic [AU_W:0]    au_full;
  logic [AU_W-1:0]  au_limit;
  logic             nr_done;
  logic             au_done;
  logic             key_req;
  logic             set_req;
  logic             next_key_reset;

  // two-stage synchronisers for the pin and each key
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_sync <= 2'h0;
    end else begin
      pin_sync <= {pin_sync[0], i_reset_pin_n};
    end
  end

  genvar gk;
  generate
    for (gk = 0; gk < KEY_W; gk++) begin : g_key_sync
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          key_meta[gk] <= 1'b1;
          key_sync[gk] <= 1'b1;
        end else begin
          key_meta[gk] <= i_key_inputs[gk];
          key_sync[gk] <= key_meta[gk];
        end
      end
    end
  endgenerate

  // key combination decode from the build option
  always_comb begin
    if (KEY_OPT == OPT_ALL4) begin
      key_mask = MASK_ALL4;
    end else if (KEY_OPT == OPT_K3) begin
      key_mask = MASK_K3;
    end else if (KEY_OPT == OPT_K2) begin
      key_mask = MASK_K2;
    end else begin
      key_mask = MASK_NONE;
    end
    // other keys may be low too: only the selected ones matter
    combo_low = (key_mask != MASK_NONE) &&
                ((key_sync & key_mask) == MASK_NONE);
    pin_low   = ~pin_sync[1];
  end

  // reject and authorize limits scale with prescaler setting plus one
  always_comb begin
    n_mul    = {1'b0, i_prescaler_setting} + (PRS_W+1)'(1);
    nr_full  = (NR_W+1)'(NR_BASE) * (NR_W+1)'(n_mul);
    nr_limit = NR_W'(nr_full - (NR_W+1)'(1));
    au_full  = (AU_W+1)'(AUTH_MUL) * (AU_W+1)'(n_mul);
    au_limit = AU_W'(au_full - (AU_W+1)'(1));
  end

  // noise rejector on the simultaneous-low condition
  ikr_low_timer #(
    .CNT_W    (NR_W)
  ) u_noise (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_active (combo_low),
    .i_limit  (nr_limit),
    .o_done   (nr_done)
  );

  // time authorize counter, only used when fitted
  ikr_low_timer #(
    .CNT_W    (AU_W)
  ) u_auth (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_active (combo_low && TIME_AUTH),
    .i_limit  (au_limit),
    .o_done   (au_done)
  );

  // key request, latch set and release divider
  always_comb begin
    key_req = nr_done && (!TIME_AUTH || au_done);
    if (i_sleep && combo_low) begin
      key_req = 1'b1;
    end
    set_req        = pin_low || key_req;
    next_rel_cnt   = rel_cnt + 1'b1;
    next_rel_tick  = (rel_cnt == REL_EDGE);
    next_key_reset = key_req || (o_key_reset && state == ST_RESET);
    next_state     = state;
    case (state)
      ST_RUN: begin
        if (set_req) begin
          next_state = ST_RESET;
        end
      end
      ST_RESET: begin
        if (!set_req && rel_tick) begin
          next_state     = ST_RUN;
          next_key_reset = 1'b0;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
  end

  // register latch, divider and outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state        <= ST_RESET;
      rel_cnt      <= '0;
      rel_tick     <= 1'b0;
      o_init_reset <= 1'b1;
      o_key_reset  <= 1'b0;
    end else begin
      state        <= next_state;
      rel_cnt      <= next_rel_cnt;
      rel_tick     <= next_rel_tick;
      o_init_reset <= (next_state == ST_RESET);
      o_key_reset  <= next_key_reset;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  pin_low_set_a: assert property (pin_low |=> o_init_reset)
    else $error("pin low did not assert reset");
  release_edge_a: assert property (
    $fell(o_init_reset) |-> $past(rel_tick))
    else $error("reset released off the divided clock edge");
  hold_until_a: assert property (
    o_init_reset && !rel_tick |=> o_init_reset)
    else $error("reset dropped before latch release");
  key_set_a: assert property (key_req |=> o_init_reset && o_key_reset)
    else $error("key request did not assert reset");
  combo_mask_a: assert property (
    combo_low |-> KEY_OPT != OPT_NONE && !key_sync[0] && !key_sync[1])
    else $error("key reset fired while disabled");
  noise_reject_a: assert property (
    $rose(nr_done) |-> $past(combo_low, 1) && $past(combo_low, 2))
    else $error("short key low passed the rejector");
  auth_gate_a: assert property (
    key_req && !i_sleep && TIME_AUTH |-> au_done)
    else $error("key reset before authorize time");
  sleep_bypass_a: assert property (i_sleep && combo_low |-> key_req)
    else $error("sleep bypass did not act");
  pin_sync_a: assert property (pin_low |-> !$past(i_reset_pin_n, 2))
    else $error("pin used without two stage sync");
endmodule : ikr_reset_gen
`default_nettype wire

// *** test/ikr_far_side.sv ***
// model of the reset switch and key switches outside the device
`timescale 1ns/10ps
`default_nettype none
module ikr_far_side (
  input  wire logic                     i_clk,
  output logic                          o_reset_pin_n,
  output logic [ikr_pkg::KEY_W-1:0]     o_key_inputs
);
  import ikr_pkg::*;
  // pin starts low so the supply ramp is covered from time zero
  initial begin
    o_reset_pin_n = 1'b0;
    o_key_inputs  = 4'hF; // keys idle high on their pull-ups
  end
  // holds the reset pin low for a number of cycles, then releases it
  task automatic hold_pin(input int cyc);
    @(posedge i_clk);
    #1 o_reset_pin_n = 1'b0;
    repeat (cyc) @(posedge i_clk);
    #1 o_reset_pin_n = 1'b1;
  endtask : hold_pin
  // presses the keys whose mask bit is set, then lets them go
  task automatic hold_keys(input logic [KEY_W-1:0] mask, input int cyc);
    @(posedge i_clk);
    #1 o_key_inputs = ~mask;
    repeat (cyc) @(posedge i_clk);
    #1 o_key_inputs = 4'hF;
  endtask : hold_keys
endmodule : ikr_far_side
`default_nettype wire

// *** test/ikr_reset_gen_bench.sv ***
// self-checking bench for the initial reset generator
`timescale 1ns/10ps
`default_nettype none
module ikr_reset_gen_bench;
  import ikr_pkg::*;
  localparam int     REL_SIM = 6;
  localparam int     REL_CYC = 1 << REL_SIM;
  localparam int     AUTH_SIM = 1024;
  logic              i_clk, i_rst, i_sleep, pin_n;
  logic [KEY_W-1:0]  keys;
  logic [PRS_W-1:0]  prs;
  logic              o_init_reset, o_key_reset;
  logic              auth_init_reset, auth_key_reset;
  int                auth_hits = 0;
  int                error_cnt, cmp_count, quiet_hits;
  // design with a short release divider, keys 0 to 2 selected
  ikr_reset_gen #(.KEY_OPT(OPT_K3), .REL_W(REL_SIM)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_reset_pin_n(pin_n),
    .i_key_inputs(keys), .i_prescaler_setting(prs), .i_sleep(i_sleep),
    .o_init_reset(o_init_reset), .o_key_reset(o_key_reset));
  // second build: keys 0 and 1 only, with the time authorize fitted
  ikr_reset_gen #(.KEY_OPT(OPT_K2), .TIME_AUTH(1'b1),
    .AUTH_MUL(AUTH_SIM), .REL_W(REL_SIM)) DUT_AUTH (
    .i_clk(i_clk), .i_rst(i_rst), .i_reset_pin_n(pin_n),
    .i_key_inputs(keys), .i_prescaler_setting(prs), .i_sleep(i_sleep),
    .o_init_reset(auth_init_reset), .o_key_reset(auth_key_reset));
  // counts cycles in which the authorize build shows reset
  always @(posedge i_clk) begin
    if (auth_init_reset === 1'b1) auth_hits <= auth_hits + 1;
  end
  ikr_far_side u_far (.i_clk(i_clk), .o_reset_pin_n(pin_n),
    .o_key_inputs(keys));
  // free-running oscillator clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic cmp(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : cmp
  // waits a bounded time for the reset output to reach a level
  task automatic wait_lvl(input logic lvl, input int bound);
    int n;
    n = 0;
    while (o_init_reset !== lvl && n < bound) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (o_init_reset !== lvl) begin
      error_cnt++;
      $display("FAIL %0t reset level not reached", $time);
      test_done();
    end
  endtask : wait_lvl
  // counts cycles in which reset shows while no reset is due
  task automatic watch(input int cyc);
    quiet_hits = 0;
    repeat (cyc) begin
      @(posedge i_clk);
      #1 if (o_init_reset !== 1'b0) quiet_hits++;
    end
  endtask : watch
  task automatic key_quiet(input logic [3:0] mask, input int cyc);
    fork
      u_far.hold_keys(mask, cyc);
      watch(cyc + 8);
    join
    cmp(quiet_hits != 0, 1'b0, "key entry gave reset");
  endtask : key_quiet
  task automatic key_hit(input logic [3:0] mask, input int cyc, bound);
    fork
      u_far.hold_keys(mask, cyc);
      begin
        wait_lvl(1'b1, bound);
        cmp(o_key_reset, 1'b1, "key source flag low");
      end
    join
    wait_lvl(1'b0, REL_CYC + 6);
    cmp(o_key_reset, 1'b0, "key flag kept after release");
  endtask : key_hit
  task automatic test_power_up();
    repeat (PIN_MIN_CYC) @(posedge i_clk);
    #1 cmp(o_init_reset, 1'b1, "reset lost while pin low");
    u_far.hold_pin(0);
    wait_lvl(1'b0, REL_CYC + 6);
    $display("power-up test done");
  endtask : test_power_up
  task automatic test_pin_run();
    fork
      u_far.hold_pin(PIN_MIN_CYC);
      wait_lvl(1'b1, 8);
    join
    cmp(o_key_reset, 1'b0, "pin reset shown as key");
    wait_lvl(1'b0, REL_CYC + 6);
    $display("pin reset test done");
  endtask : test_pin_run
  task automatic test_keys();
    int auth_base;
    auth_base = auth_hits;
    key_quiet(4'h7, NR_BASE - 8);
    @(posedge i_clk);
    #1 prs = 4'h1;
    key_quiet(4'h7, 2 * NR_BASE - 8);
    key_hit(4'h7, 6 * NR_BASE, 2 * NR_BASE + 12);
    key_quiet(4'hB, 4 * NR_BASE);
    key_hit(4'hF, 6 * NR_BASE, 2 * NR_BASE + 12);
    cmp(auth_hits != auth_base, 1'b0, "short entry beat authorize");
    $display("key reset test done");
  endtask : test_keys
  // two keys: only the authorize build resets, after its full time
  task automatic test_auth();
    fork
      u_far.hold_keys(4'h3, 2 * AUTH_SIM + 150);
      begin
        repeat (2 * AUTH_SIM) @(posedge i_clk);
        #1 cmp(auth_init_reset, 1'b0, "authorize passed early");
        cmp(o_init_reset, 1'b0, "two keys reset three key build");
        repeat (12) @(posedge i_clk);
        #1 cmp(auth_init_reset, 1'b1, "authorize never passed");
        cmp(auth_key_reset, 1'b1, "two key entry gave no flag");
        cmp(o_init_reset, 1'b0, "two keys reset three key build");
      end
    join
    repeat (REL_CYC + 6) @(posedge i_clk);
    #1 cmp(auth_init_reset, 1'b0, "authorize reset not released");
    cmp(auth_key_reset, 1'b0, "authorize key flag kept");
    $display("authorize test done");
  endtask : test_auth
  task automatic test_sleep();
    @(posedge i_clk);
    #1 i_sleep = 1'b1;
    key_hit(4'h7, 8, 12);
    @(posedge i_clk);
    #1 i_sleep = 1'b0;
    $display("sleep bypass test done");
  endtask : test_sleep
  // reset for 16 cycles, then the scenarios in turn
  initial begin
    i_rst     = 1'b1;
    i_sleep   = 1'b0;
    prs       = 4'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (16) @(posedge i_clk);
    #1 i_rst = 1'b0;
    test_power_up();
    test_pin_run();
    test_keys();
    test_auth();
    test_sleep();
    test_done();
  end
endmodule : ikr_reset_gen_bench
`default_nettype wire
